// file: common/didf_pkg.sv
package didf_pkg;
  // Function codes for each contact input
  localparam logic [7:0] FC_NONE = 8'h00;
  localparam logic [7:0] FC_HOLD = 8'h01;
  localparam logic [7:0] FC_TUNE = 8'h1e;
  localparam logic [7:0] FC_LATCH_REL = 8'h28;
  localparam logic [7:0] FC_TIMER_FIRST = 8'h32;
  localparam logic [7:0] FC_TIMER_LAST = 8'h39;
  localparam logic [7:0] FC_REMOTE = 8'h3c;
  localparam logic [7:0] FC_MANUAL = 8'h46;
  localparam logic [7:0] FC_TRACK = 8'h50;
  localparam logic [7:0] FC_EXT_OUT = 8'h67;
  localparam logic [7:0] FC_SELECTOR = 8'h8c;
  localparam logic [7:0] FC_TOT_HOLD = 8'ha0;
  localparam logic [7:0] FC_TOT_LATCH = 8'ha1;
  localparam logic [7:0] FC_TOT_RESET = 8'ha2;
  // Alarm type codes that carry a timer
  localparam logic [7:0] ALM_TIMER_FIRST = 8'h24;
  localparam logic [7:0] ALM_TIMER_LAST = 8'h26;
  // Control templates that allow remote and manual switching
  localparam logic [7:0] TEMPLATE_A = 8'h1e;
  localparam logic [7:0] TEMPLATE_B = 8'h21;
  localparam int BASE_INPUTS = 4;
  localparam int MAX_INPUTS = 9;
  localparam int NUM_ALARMS = 8;

  // Level commands delivered to the controller
  typedef struct packed {
    logic control_hold_request;
    logic remote_select;
    logic manual_output_command;
    logic setpoint_follows_process;
    logic external_output_value;
    logic hi_selector;
    logic tot_hold;
    logic tot_latch;
    logic tot_reset;
  } didf_level_t;

  // Single-cycle commands
  typedef struct packed {
    logic tune_start;
    logic tune_stop;
    logic latch_release;
  } didf_pulse_t;
endpackage

// file: src/didf_dispatch.sv
`timescale 1ns/1ps
`default_nettype none
module didf_dispatch
  import didf_pkg::*;
#(
  parameter int NUM_INPUTS = MAX_INPUTS
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic [NUM_INPUTS-1:0] i_contact,
  input wire logic [NUM_INPUTS*8-1:0] i_function_code,
  input wire logic [NUM_ALARMS*8-1:0] i_alarm_type,
  input wire logic [7:0] i_control_template,
  input wire logic i_remote_ack_enable,
  input wire logic i_remote_mode_select,
  input wire logic i_tuning_type_select,
  output logic o_tuning_low_process,
  output didf_level_t o_level,
  output didf_pulse_t o_pulse,
  output logic [NUM_ALARMS-1:0] o_alarm_timer_enable
);

  // Only the base and extended builds exist; other counts stop elaboration
  // input count check
  if (NUM_INPUTS != BASE_INPUTS && NUM_INPUTS != MAX_INPUTS) begin : g_bad_count
    $error("NUM_INPUTS must be 4 or 9");
  end

  function automatic logic [7:0] code_of(input logic [NUM_INPUTS*8-1:0] codes, input int idx);
    code_of = codes[idx*8 +: 8];
  endfunction

  function automatic logic template_ok(input logic [7:0] t);
    template_ok = (t == TEMPLATE_A) || (t == TEMPLATE_B);
  endfunction

  logic [NUM_INPUTS-1:0] sync_a;
  logic [NUM_INPUTS-1:0] sync_b;
  logic [NUM_INPUTS-1:0] prev;
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      sync_a <= '0;
      sync_b <= '0;
      prev <= '0;
    end else begin
      sync_a <= i_contact;
      sync_b <= sync_a;
      prev <= sync_b;
    end
  end

  logic [NUM_INPUTS-1:0] rise;
  logic [NUM_INPUTS-1:0] fall;
  assign rise = sync_b & ~prev;
  assign fall = ~sync_b & prev;

  // Decode every input into level and pulse requests; several inputs on
  // one function are OR'ed so any closed contact asserts the command.
  didf_level_t next_level;
  didf_pulse_t next_pulse;
  logic [NUM_ALARMS-1:0] next_timer;
  always_comb begin
    logic [7:0] fc;
    logic lv;
    fc = 8'h00;
    lv = 1'b0;
    next_level = '0;
    next_pulse = '0;
    next_timer = '0;
    for (int i = 0; i < NUM_INPUTS; i++) begin
      fc = code_of(i_function_code, i);
      lv = sync_b[i];
      case (fc)
        FC_HOLD: next_level.control_hold_request |= lv;
        FC_TUNE: begin
          next_pulse.tune_start |= rise[i];
          next_pulse.tune_stop |= fall[i];
        end
        FC_LATCH_REL: next_pulse.latch_release |= rise[i];
        FC_REMOTE: next_level.remote_select |= lv;
        FC_MANUAL: next_level.manual_output_command |= lv;
        FC_TRACK: next_level.setpoint_follows_process |= lv;
        FC_EXT_OUT: next_level.external_output_value |= lv;
        FC_SELECTOR: next_level.hi_selector |= lv;
        FC_TOT_HOLD: next_level.tot_hold |= lv;
        FC_TOT_LATCH: next_level.tot_latch |= lv;
        FC_TOT_RESET: next_level.tot_reset |= lv;
        default: begin
          if (fc >= FC_TIMER_FIRST && fc <= FC_TIMER_LAST) begin
            next_timer[3'(fc - FC_TIMER_FIRST)] |= lv;
          end
        end
      endcase
    end
    next_level.remote_select &= template_ok(i_control_template) & i_remote_ack_enable
      & i_remote_mode_select;
    // manual needs template; template taken as settled
    next_level.manual_output_command &= template_ok(i_control_template);
    for (int a = 0; a < NUM_ALARMS; a++) begin
      if (i_alarm_type[a*8 +: 8] < ALM_TIMER_FIRST || i_alarm_type[a*8 +: 8] > ALM_TIMER_LAST) begin
        next_timer[a] = 1'b0;
      end
    end
  end

  // Registered outputs
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_level <= '0;
      o_pulse <= '0;
      o_alarm_timer_enable <= '0;
      o_tuning_low_process <= 1'b0;
    end else begin
      o_level <= next_level;
      o_pulse <= next_pulse;
      o_alarm_timer_enable <= next_timer;
      o_tuning_low_process <= i_tuning_type_select;
    end
  end

  logic fc0_hold;
  logic fc0_tune;
  assign fc0_hold = code_of(i_function_code, 0) == FC_HOLD;
  assign fc0_tune = code_of(i_function_code, 0) == FC_TUNE;

  // Inputs on the tuning code; OR'ed inputs may legally pulse back to back
  logic [NUM_INPUTS-1:0] tune_inputs;
  for (genvar g = 0; g < NUM_INPUTS; g++) begin : g_tune_inputs
    assign tune_inputs[g] = code_of(i_function_code, g) == FC_TUNE;
  end

  property p_hold;
    @(posedge i_clk_sys) disable iff (i_rst)
      $stable(i_function_code) && fc0_hold && sync_b[0] |=> o_level.control_hold_request;
  endproperty
  standby_level_a: assert property (p_hold) else $error("standby not asserted");

  tune_start_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    $stable(i_function_code) && fc0_tune && rise[0] |=> o_pulse.tune_start)
    else $error("tune start missing");
  tune_pulse_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    $stable(i_function_code) && $onehot(tune_inputs) && o_pulse.tune_start
      |=> !o_pulse.tune_start)
    else $error("tune start longer than one cycle");
  latch_rel_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    $stable(i_function_code) && code_of(i_function_code, 0) == FC_LATCH_REL && rise[0]
      |=> o_pulse.latch_release)
    else $error("latch release missing");
  timer_type_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_alarm_timer_enable[0] |-> $past(i_alarm_type[7:0]) >= ALM_TIMER_FIRST
      && $past(i_alarm_type[7:0]) <= ALM_TIMER_LAST)
    else $error("timer enabled for wrong alarm type");
  remote_gate_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_level.remote_select |-> $past(i_remote_ack_enable) && $past(i_remote_mode_select))
    else $error("remote without enables");
  manual_gate_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_level.manual_output_command |-> template_ok($past(i_control_template)))
    else $error("manual with wrong template");
  inert_code_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_function_code == '0) [*2] |-> o_level == '0 && o_pulse == '0 && o_alarm_timer_enable == '0)
    else $error("code zero had effect");
  sync_delay_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    rise[0] |-> $past(i_contact[0], 2))
    else $error("edge without synchronised sample");
  // Input 0 carries the direct checks; the bench draws its code at random from a 16-entry list
  tune_stop_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    $stable(i_function_code) && fc0_tune && fall[0] |=> o_pulse.tune_stop)
    else $error("tune stop missing");
  track_level_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    $stable(i_function_code) && code_of(i_function_code, 0) == FC_TRACK && sync_b[0]
      |=> o_level.setpoint_follows_process)
    else $error("tracking not asserted");
  timer_follow_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    $stable(i_function_code) && code_of(i_function_code, 0) == FC_TIMER_FIRST && sync_b[0]
      && i_alarm_type[7:0] >= ALM_TIMER_FIRST && i_alarm_type[7:0] <= ALM_TIMER_LAST
      |=> o_alarm_timer_enable[0])
    else $error("alarm timer not enabled");

  // Main scenarios the bench should reach
  tune_cycle_c: cover property (@(posedge i_clk_sys) o_pulse.tune_start ##[1:50] o_pulse.tune_stop);
  remote_c: cover property (@(posedge i_clk_sys) o_level.remote_select);
  timer_c: cover property (@(posedge i_clk_sys) o_alarm_timer_enable[7]);
  latch_rel_c: cover property (@(posedge i_clk_sys) o_pulse.latch_release);
  manual_c: cover property (@(posedge i_clk_sys) o_level.manual_output_command);

endmodule
`default_nettype wire

// file: verification/didf_switches.sv
`timescale 1ns/1ps
`default_nettype none
// Contact switches: a moved contact settles 1 to 3 rising edges later
module didf_switches (
  input wire logic i_clk_sys,
  input wire logic [8:0] i_want,
  output logic [8:0] o_contact
);
  int seed = 71;
  int settle = 0;
  initial o_contact = '0;
  // Slow contacts exercise the synchroniser with varying arrival times
  // Moves on the rising edge so the bench's falling-edge requests are settled
  always @(posedge i_clk_sys) begin
    if (i_want == o_contact) begin
      settle <= $unsigned($random(seed)) % 3;
    end else if (settle == 0) begin
      o_contact <= i_want;
    end else begin
      settle <= settle - 1;
    end
  end
endmodule
`default_nettype wire

// file: verification/test_didf_dispatch.sv
`timescale 1ns/1ps
`default_nettype none
module test_didf_dispatch;
  import didf_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_rst = 1'b1;
  logic [8:0] want = '0;
  logic [8:0] contact;
  logic [71:0] fc = '0;
  logic [63:0] atype = '0;
  logic [7:0] tmpl_code = '0;
  logic [7:0] pick_tmpl;
  logic ack = 1'b0, mode = 1'b0, ttype = 1'b0, low_tune;
  didf_level_t lvl;
  didf_pulse_t pul;
  logic [7:0] tmr;
  int failures = 0, samples_checked = 0, seed = 71, n_st, n_sp, n_rl;
  logic [7:0] codes [16] = '{FC_NONE, FC_HOLD, FC_TUNE, FC_LATCH_REL, FC_TIMER_FIRST, 8'h35,
    FC_TIMER_LAST, FC_REMOTE, FC_MANUAL, FC_TRACK, FC_EXT_OUT, FC_SELECTOR, FC_TOT_HOLD,
    FC_TOT_LATCH, FC_TOT_RESET, 8'h02};
  logic [7:0] templates [3] = '{TEMPLATE_A, TEMPLATE_B, 8'h1f};
  always #12.5 i_clk_sys = ~i_clk_sys;
  didf_switches SW (.i_clk_sys(i_clk_sys), .i_want(want), .o_contact(contact));
  didf_dispatch #(.NUM_INPUTS(9)) DUT (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .i_contact(contact), .i_function_code(fc), .i_alarm_type(atype),
    .i_control_template(tmpl_code), .i_remote_ack_enable(ack), .i_remote_mode_select(mode),
    .i_tuning_type_select(ttype), .o_tuning_low_process(low_tune), .o_level(lvl),
    .o_pulse(pul), .o_alarm_timer_enable(tmr));
  // Expected levels; unknown codes and code 0 leave everything low
  function automatic didf_level_t exp_lv(input logic [71:0] f, input logic [8:0] c);
    didf_level_t e;
    logic tp;
    e = '0;
    tp = (tmpl_code == TEMPLATE_A) || (tmpl_code == TEMPLATE_B);
    for (int i = 0; i < 9; i++) begin
      if (c[i]) begin
        case (f[i*8+:8])
          FC_HOLD: e.control_hold_request = 1'b1;
          FC_REMOTE: e.remote_select = tp & ack & mode;
          FC_MANUAL: e.manual_output_command = tp;
          FC_TRACK: e.setpoint_follows_process = 1'b1;
          FC_EXT_OUT: e.external_output_value = 1'b1;
          FC_SELECTOR: e.hi_selector = 1'b1;
          FC_TOT_HOLD: e.tot_hold = 1'b1;
          FC_TOT_LATCH: e.tot_latch = 1'b1;
          FC_TOT_RESET: e.tot_reset = 1'b1;
          default: ;
        endcase
      end
    end
    return e;
  endfunction
  // Expected timer enables; only timer alarm types follow the input
  function automatic logic [7:0] exp_tm(input logic [71:0] f, input logic [8:0] c);
    logic [7:0] e;
    logic [7:0] k;
    e = '0;
    for (int i = 0; i < 9; i++) begin
      k = f[i*8+:8] - FC_TIMER_FIRST;
      if (c[i] && f[i*8+:8] >= FC_TIMER_FIRST && f[i*8+:8] <= FC_TIMER_LAST)
        e[k[2:0]] = e[k[2:0]] | (atype[k[2:0]*8+:8] >= ALM_TIMER_FIRST
          && atype[k[2:0]*8+:8] <= ALM_TIMER_LAST);
    end
    return e;
  endfunction
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic test_done();
    $display("failures=%0d samples_checked=%0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Counts high cycles of each pulse; a window longer than the latency
  task automatic pulse_run(input logic [8:0] w, input int es, input int ep, input int er);
    n_st = 0;
    n_sp = 0;
    n_rl = 0;
    want = w;
    repeat (10) begin
      @(negedge i_clk_sys);
      n_st += pul.tune_start === 1'b1;
      n_sp += pul.tune_stop === 1'b1;
      n_rl += pul.latch_release === 1'b1;
    end
    chk(16'(n_st), 16'(es));
    chk(16'(n_sp), 16'(ep));
    chk(16'(n_rl), 16'(er));
  endtask
  initial begin
    #500000;
    failures++;
    test_done();
  end
  initial begin
    repeat (16) @(negedge i_clk_sys);
    i_rst = 1'b0;
    // Edge commands: tuning on extended input 8, latch release on input 0, both tuning types
    fc = {FC_TUNE, 56'h0, FC_LATCH_REL};
    for (int t = 0; t < 2; t++) begin
      ttype = t[0];
      pulse_run(9'h101, 1, 0, 1);
      pulse_run(9'h000, 0, 1, 0);
      chk(16'(low_tune), 16'(ttype));
    end
    // Code 0 on every input: contacts move and nothing answers
    fc = '0;
    pulse_run(9'h1ff, 0, 0, 0);
    chk(16'(lvl), 16'h0000);
    chk(16'(tmr), 16'h0000);
    pulse_run(9'h000, 0, 0, 0);
    // Random codes, gates and contacts; levels must settle
    repeat (300) begin
      for (int i = 0; i < 9; i++) fc[i*8+:8] = codes[$unsigned($random(seed)) % 16];
      for (int a = 0; a < 8; a++) atype[a*8+:8] = 8'h23 + 8'($unsigned($random(seed)) % 5);
      pick_tmpl = templates[$unsigned($random(seed)) % 3];
      // a new template is always followed by a reset
      if (pick_tmpl != tmpl_code) begin
        i_rst = 1'b1;
        tmpl_code = pick_tmpl;
        @(negedge i_clk_sys);
        chk(16'({lvl, pul}), 16'h0000);
        i_rst = 1'b0;
      end
      {ack, mode} = 2'($random(seed));
      want = 9'($random(seed));
      repeat (8) @(negedge i_clk_sys);
      chk(16'(lvl), 16'(exp_lv(fc, contact)));
      chk(16'(tmr), 16'(exp_tm(fc, contact)));
    end
    test_done();
  end
endmodule
`default_nettype wire
